// ### design/mfa_pkg.sv
package mfa_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_AVG_LOWER = 8'h3e;
    localparam logic [7:0] IDX_AVG_UPPER = 8'h3f;
    localparam logic [7:0] IDX_AVG_CTRL = 8'h40;
    localparam logic [7:0] IDX_SAMPLE = 8'h50;

    // reset values
    localparam logic [7:0] RST_AVG_LOWER = 8'h00;
    localparam logic [7:0] RST_AVG_UPPER = 8'h00;
    localparam logic [7:0] RST_AVG_CTRL = 8'h88;

    // control field positions
    localparam int BIT_AVG_EN = 7;
    localparam int BIT_AVG_FAST = 6;
    localparam int BIT_READ_EN = 5;
    localparam int MSB_HI_VALUE = 2;

    // value layout
    localparam int FREQ_W = 19;

    // ppm per lsb, times 1e7
    localparam int PPM_LSB_E7 = 3068;

    // averaging shifts: fast responds quicker than slow
    localparam int SHIFT_FAST = 4;
    localparam int SHIFT_SLOW = 10;

endpackage : mfa_pkg

// ### design/mfa_averager.sv
//////////////////////////////////////////////////////////////////////////////
// Function
// - 19-bit signed value from three registers
// - one lsb equals 0.0003068 ppm offset
// - control bit 7 enables extra averaging
// - control bit 6 selects fast or slow
// - control resets to 1000 1000
// - upper byte rw, bits 15:8, reset zero
// - lower byte rw, bits 7:0, reset zero
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module mfa_averager
    import mfa_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // raw frequency from the monitor loop
    input wire logic [18:0] raw_freq,
    input wire logic raw_valid,
    // averaged value, lsb = 0.0003068 ppm
    output logic [18:0] avg_freq
);

    //////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] reg_lower;
    logic [7:0] reg_upper;
    logic [7:0] reg_ctrl;
    logic [7:0] next_lower;
    logic [7:0] next_upper;
    logic [7:0] next_ctrl;
    logic [31:0] acc;
    logic [31:0] next_acc;
    logic [31:0] next_prdata;
    logic wr_acc;
    logic rd_acc;
    logic rd_setup;
    logic [29:0] word;
    logic [31:0] raw_ext;
    logic [31:0] step;
    logic [31:0] avg_word;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    // read setup cycle: the read word is captured here, ahead of access
    assign rd_setup = psel && !penable && !pwrite;
    assign word = paddr[31:2];
    // single-cycle access phase, never an error
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // sign extend the raw sample, 13 fraction-free guard bits are unused
    assign raw_ext = {{13{raw_freq[FREQ_W-1]}}, raw_freq};
    // one pole filter: acc += (raw - acc) >>> shift
    assign step = reg_ctrl[BIT_AVG_FAST]
        ? 32'($signed(raw_ext - acc) >>> SHIFT_FAST)
        : 32'($signed(raw_ext - acc) >>> SHIFT_SLOW);

    // averaging and register update; a bus write wins over the readout copy
    always_comb begin
        next_acc = acc;
        next_lower = reg_lower;
        next_upper = reg_upper;
        next_ctrl = reg_ctrl;
        if (raw_valid) begin
            if (reg_ctrl[BIT_AVG_EN]) begin
                next_acc = acc + step;
            end else begin
                next_acc = raw_ext;
            end
        end
        // readout registers follow the average unless readout is blocked
        avg_word = next_acc;
        if (raw_valid && reg_ctrl[BIT_READ_EN]) begin
            next_lower = avg_word[7:0];
            next_upper = avg_word[15:8];
            next_ctrl = {reg_ctrl[7:3], avg_word[18:16]};
        end
        if (wr_acc) begin
            case (word)
                {22'h00_0000, IDX_AVG_LOWER}: next_lower = pwdata[7:0];
                {22'h00_0000, IDX_AVG_UPPER}: next_upper = pwdata[7:0];
                {22'h00_0000, IDX_AVG_CTRL}: next_ctrl = pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acc <= 32'h0000_0000;
            reg_lower <= RST_AVG_LOWER;
            reg_upper <= RST_AVG_UPPER;
            reg_ctrl <= RST_AVG_CTRL;
        end else begin
            acc <= next_acc;
            reg_lower <= next_lower;
            reg_upper <= next_upper;
            reg_ctrl <= next_ctrl;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read data path; unmapped words read as zero
    // the word is picked in the setup cycle so that the access phase sees
    // a registered value and still needs no wait state
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (rd_setup) begin
            case (word)
                {22'h00_0000, IDX_AVG_LOWER}:
                    next_prdata = {24'h00_0000, reg_lower};
                {22'h00_0000, IDX_AVG_UPPER}:
                    next_prdata = {24'h00_0000, reg_upper};
                {22'h00_0000, IDX_AVG_CTRL}:
                    next_prdata = {24'h00_0000, reg_ctrl};
                {22'h00_0000, IDX_SAMPLE}:
                    next_prdata = raw_ext;
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // read data register; a sample landing on the setup edge shows up in
    // the next read, not this one, which keeps the word stable in access
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

    // concatenated 19-bit value, scale
    assign avg_freq = {reg_ctrl[MSB_HI_VALUE:0], reg_upper, reg_lower};

    //////////////////////////////////////////////////////////////////////////
    // checks
    // reset values
    a_ctrl_reset: assert property (@(posedge core_clk)
        $fell(rst) |-> reg_ctrl == RST_AVG_CTRL)
        else $error("control reset value wrong");
    a_regs_reset: assert property (@(posedge core_clk)
        $fell(rst) |-> reg_lower == RST_AVG_LOWER
            && reg_upper == RST_AVG_UPPER)
        else $error("byte register reset value wrong");

    // readout copy: the three registers take the new average together
    a_copy_out: assert property (@(posedge core_clk) disable iff (rst)
        raw_valid && reg_ctrl[BIT_READ_EN] && !wr_acc
        |=> avg_freq == acc[FREQ_W-1:0])
        else $error("readout copy wrong");

    // averaging arithmetic in each mode
    a_bypass_raw: assert property (@(posedge core_clk) disable iff (rst)
        raw_valid && !reg_ctrl[BIT_AVG_EN] |=> acc == $past(raw_ext))
        else $error("bypass did not pass raw");
    a_fast_step: assert property (@(posedge core_clk) disable iff (rst)
        raw_valid && reg_ctrl[BIT_AVG_EN] && reg_ctrl[BIT_AVG_FAST]
        |=> acc == $past(acc) + 32'($signed($past(raw_ext) - $past(acc))
            >>> SHIFT_FAST))
        else $error("fast step wrong");
    a_slow_step: assert property (@(posedge core_clk) disable iff (rst)
        raw_valid && reg_ctrl[BIT_AVG_EN] && !reg_ctrl[BIT_AVG_FAST]
        |=> acc == $past(acc) + 32'($signed($past(raw_ext) - $past(acc))
            >>> SHIFT_SLOW))
        else $error("slow step wrong");

    // bus writes
    a_upper_write: assert property (@(posedge core_clk) disable iff (rst)
        wr_acc && word == {22'h00_0000, IDX_AVG_UPPER}
        |=> reg_upper == $past(pwdata[7:0]))
        else $error("upper write lost");
    a_lower_write: assert property (@(posedge core_clk) disable iff (rst)
        wr_acc && word == {22'h00_0000, IDX_AVG_LOWER}
        |=> reg_lower == $past(pwdata[7:0]))
        else $error("lower write lost");
    a_ctrl_write: assert property (@(posedge core_clk) disable iff (rst)
        wr_acc && word == {22'h00_0000, IDX_AVG_CTRL}
        |=> reg_ctrl == $past(pwdata[7:0]))
        else $error("control write lost");

    // frozen readout while software keeps the read enable clear
    a_hold_noread: assert property (@(posedge core_clk) disable iff (rst)
        !reg_ctrl[BIT_READ_EN] && !wr_acc |=> $stable(reg_upper))
        else $error("upper moved while readout blocked");
    a_hold_lower: assert property (@(posedge core_clk) disable iff (rst)
        !reg_ctrl[BIT_READ_EN] && !wr_acc |=> $stable(reg_lower))
        else $error("lower moved while readout blocked");

    // read path: the word captured at setup stands in the access phase
    a_read_ctrl: assert property (@(posedge core_clk) disable iff (rst)
        rd_setup && word == {22'h00_0000, IDX_AVG_CTRL}
        |=> prdata == {24'h00_0000, $past(reg_ctrl)})
        else $error("control readback wrong");
    a_read_lower: assert property (@(posedge core_clk) disable iff (rst)
        rd_setup && word == {22'h00_0000, IDX_AVG_LOWER}
        |=> prdata == {24'h00_0000, $past(reg_lower)})
        else $error("lower readback wrong");
    a_read_upper: assert property (@(posedge core_clk) disable iff (rst)
        rd_setup && word == {22'h00_0000, IDX_AVG_UPPER}
        |=> prdata == {24'h00_0000, $past(reg_upper)})
        else $error("upper readback wrong");

    // main scenarios: each averaging mode, frozen readout and a readback
    c_fast: cover property (@(posedge core_clk)
        raw_valid && reg_ctrl[BIT_AVG_EN] && reg_ctrl[BIT_AVG_FAST]);
    c_slow: cover property (@(posedge core_clk)
        raw_valid && reg_ctrl[BIT_AVG_EN] && !reg_ctrl[BIT_AVG_FAST]);
    c_bypass: cover property (@(posedge core_clk)
        raw_valid && !reg_ctrl[BIT_AVG_EN]);
    c_freeze: cover property (@(posedge core_clk)
        raw_valid && !reg_ctrl[BIT_READ_EN]);
    c_read_ctrl: cover property (@(posedge core_clk)
        rd_setup && word == {22'h00_0000, IDX_AVG_CTRL});

endmodule : mfa_averager

// ### verification/mfa_testbench.sv
`timescale 1ns/1ps

module testbench;
    import mfa_pkg::*;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic err;
    logic raw_valid = 1'b0;
    logic [18:0] raw_freq = 19'h0_0000;
    logic [18:0] avg_freq;
    int mismatches = 0;
    int checks = 0;
    // byte address is four times the register index
    localparam logic [31:0] A_LO = {22'h0, IDX_AVG_LOWER, 2'b00};
    localparam logic [31:0] A_UP = {22'h0, IDX_AVG_UPPER, 2'b00};
    localparam logic [31:0] A_CT = {22'h0, IDX_AVG_CTRL, 2'b00};
    localparam logic [31:0] A_SM = {22'h0, IDX_SAMPLE, 2'b00};

    mfa_averager u_dut (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .raw_freq(raw_freq), .raw_valid(raw_valid), .avg_freq(avg_freq));

    //////////////////////////////////////////////////////////////////////////
    // clock at 40 MHz
    always #12.5 core_clk = ~core_clk;

    // one apb transfer; waits on pready, no fixed latency assumed
    task automatic apb(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic rc(input logic [31:0] a, e);
        apb(1'b0, a, 32'h0000_0000, rd);
        chk(rd, e);
        chk({31'h0000_0000, err}, 32'h0000_0000);
    endtask : rc

    task automatic wr(input logic [31:0] a, d);
        apb(1'b1, a, d, rd);
    endtask : wr

    // two samples; the second equals the new average, so copy timing
    // (old or updated accumulator) cannot change the readout
    task automatic raw2(input logic [18:0] v1, v2);
        @(posedge core_clk);
        raw_freq <= v1;
        raw_valid <= 1'b1;
        @(posedge core_clk);
        raw_freq <= v2;
        @(posedge core_clk);
        raw_valid <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : raw2

    task automatic complete_run;
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    //////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        complete_run();
    end

    // main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        rc(A_LO, 32'h0000_0000);
        rc(A_UP, 32'h0000_0000);
        rc(A_CT, 32'h0000_0088);
        wr(A_LO, 32'h0000_0034);
        wr(A_UP, 32'h0000_0012);
        wr(A_CT, 32'h0000_008d);
        rc(A_LO, 32'h0000_0034);
        rc(A_UP, 32'h0000_0012);
        rc(A_CT, 32'h0000_008d);
        chk({13'h0, avg_freq}, 32'h0005_1234);
        // unmapped place reads zero
        rc(32'h0000_0200, 32'h0000_0000);
        // averaging off: readout follows the raw sample
        wr(A_CT, 32'h0000_0028);
        raw2(19'h1_2345, 19'h1_2345);
        rc(A_LO, 32'h0000_0045);
        rc(A_UP, 32'h0000_0023);
        rc(A_CT, 32'h0000_0029);
        // fast: step of 0x100 moves the average by 0x10
        wr(A_CT, 32'h0000_00e8);
        raw2(19'h1_2445, 19'h1_2355);
        rc(A_LO, 32'h0000_0055);
        // slow: step of 0x400 moves the average by one lsb
        wr(A_CT, 32'h0000_00a8);
        raw2(19'h1_2755, 19'h1_2356);
        rc(A_LO, 32'h0000_0056);
        chk({13'h0, avg_freq}, 32'h0001_2356);
        // readout frozen while bit 5 is clear; the average keeps moving
        wr(A_CT, 32'h0000_0088);
        raw2(19'h1_2756, 19'h1_2357);
        rc(A_LO, 32'h0000_0056);
        rc(A_CT, 32'h0000_0088);
        wr(A_CT, 32'h0000_00a8);
        raw2(19'h1_2357, 19'h1_2357);
        rc(A_LO, 32'h0000_0057);
        rc(A_CT, 32'h0000_00a9);
        // negative value with averaging off, then the raw sample word
        wr(A_CT, 32'h0000_0028);
        raw2(19'h7_ff00, 19'h7_ff00);
        rc(A_UP, 32'h0000_00ff);
        rc(A_CT, 32'h0000_002f);
        chk({13'h0, avg_freq}, 32'h0007_ff00);
        rc(A_SM, 32'hffff_ff00);
        complete_run();
    end

endmodule : testbench
